// File: design/fsk_modem_cfg.svh
// Constants for the FSK modem interface-control block
`ifndef FSK_MODEM_CFG_SVH
`define FSK_MODEM_CFG_SVH
// -----------------------------------------
// Clock and tick
// -----------------------------------------
`define CLK_NS       32'h0000_0005
`define CLK_HZ       64'h0000_0000_0BEB_C200
`define TICK_NS      32'h0001_86A0
// Tuning-word multiplier, 2^44 / clock rate
`define FTW_MULT     17'((64'h0000_1000_0000_0000) / `CLK_HZ)
`define FTW_SHIFT    12
// -----------------------------------------
// Mode codes
// -----------------------------------------
`define MODE_B103O   4'h0
`define MODE_B103A   4'h1
`define MODE_B202    4'h2
`define MODE_B202EQ  4'h3
`define MODE_V21O    4'h4
`define MODE_V21A    4'h5
`define MODE_V23M2   4'h6
`define MODE_V23M2EQ 4'h7
`define MODE_V23M1   4'h8
`define MODE_V23BKLB 5'h19
// -----------------------------------------
// Frequencies in Hz
// -----------------------------------------
`define HZ_1070 12'h42E
`define HZ_1270 12'h4F6
`define HZ_2025 12'h7E9
`define HZ_2225 12'h8B1
`define HZ_1180 12'h49C
`define HZ_980  12'h3D4
`define HZ_1850 12'h73A
`define HZ_1650 12'h672
`define HZ_1700 12'h6A4
`define HZ_1300 12'h514
`define HZ_2100 12'h834
`define HZ_2200 12'h898
`define HZ_1200 12'h4B0
`define HZ_450  12'h1C2
`define HZ_390  12'h186
`define HZ_387  12'h183
// -----------------------------------------
// Delays in 0.1 ms ticks
// -----------------------------------------
`define T_RCON_300   15'h0823
`define T_RCON_V21   15'h0FA0
`define T_RCON_202   15'h0729
`define T_RCOFF      15'h0005
`define T_BRCON      15'h0337
`define T_CDON_US300 15'h03E8
`define T_CDON_V21   15'h0BF9
`define T_CDON_V23   15'h0086
`define T_CDON_202   15'h00C8
`define T_CDOFF_FULL 15'h012C
`define T_CDOFF_V23  15'h005E
`define T_CDOFF_202  15'h00B4
`define T_BCDON      15'h00D2
`define T_BCDOFF     15'h0127
`define T_SIL_US     15'h32C8
`define T_SIL_CCITT  15'h4A38
`define T_AT_SHORT   15'h4A38
`define T_AT_LONG    15'h7530
`define T_SQ         15'h061B
`define T_STO        15'h00F0
`endif

// File: design/fsk_modem_pkg.sv
// Types shared by the FSK modem interface-control block
package fsk_modem_pkg;
   typedef enum logic [3:0] {
      TX_INIT      = 4'h0,
      TX_IDLE      = 4'h1,
      TX_SIL       = 4'h2,
      TX_ANS       = 4'h3,
      TX_MAIN_WAIT = 4'h4,
      TX_MAIN_ON   = 4'h5,
      TX_MAIN_OFF  = 4'h6,
      TX_BACK_WAIT = 4'h7,
      TX_BACK_ON   = 4'h8,
      TX_BACK_OFF  = 4'h9
   } tx_state_t;
   typedef enum logic [2:0] {
      RX_INIT = 3'h0,
      RX_NONE = 3'h1,
      RX_QUAL = 3'h2,
      RX_PRES = 3'h3,
      RX_LOSS = 3'h4
   } rx_state_t;
   typedef struct packed {
      logic us300;
      logic v21;
      logic v23;
      logic b202;
      logic half;
      logic answer;
      logic loop;
      logic valid;
   } mode_dec_t;
endpackage : fsk_modem_pkg

// File: design/fsk_modem_interface_control.sv
// Interface control of an FSK modem: handshake machines, delays, mode decode
// What this block does
// - Transmit one tone for mark, another for space, phase continuous
// - Mode decode picks transmit tones and transmit/receive filter channels
// - Tone frequencies per mode follow the frequency table
// - Tones within 0.4 Hz of nominal from the master clock
// - Two machines: transmit with auto-answer, and reception
// - Both machines start in initial conditions until terminal ready
// - Terminal ready dropping returns everything to initial conditions within 25 us
// - Initial conditions: grants and carrier flags off, data ignored, receive mark
// - Back channel signals dead in full-duplex modes
// - Full duplex 300 baud; half duplex main and back opposite channels
// - Send grant on after 208.3, 400 or 183.3 ms per mode
// - Send grant off 0.5 ms after request drops
// - Back grant on 82.3 ms after back request in V.23
// - Carrier flag on after mode-dependent qualification time
// - Carrier flag off after mode-dependent loss time
// - Back carrier flag on 17-25 ms, off 21-38 ms
// - Auto-answer silence 1.3 s or 1.9 s before answer tone
// - US 1200 modes send 24 ms soft turn-off tone
// - US 1200 back mode: 387 Hz only with back request low, data high
// - US 1200 back mode: back carrier flag low while 387 Hz received
// - Received data forced to mark whenever possibly invalid
// - Mark is high and logic one, space low and logic zero
// - Five-bit mode code selects modem type; reserved codes unused
`include "fsk_modem_cfg.svh"
module fsk_modem_interface_control #(
   parameter int TICK_CYCLES = `TICK_NS / `CLK_NS,
   parameter int ACC_W       = 32
) (
   input  wire logic       i_clock,
   input  wire logic       i_sys_rst,
   input  wire logic       i_terminal_ready_n,
   input  wire logic       i_send_request_n,
   input  wire logic       i_back_send_request_n,
   input  wire logic       i_main_tx_serial,
   input  wire logic       i_back_tx_serial,
   input  wire logic       i_ring_n,
   input  wire logic [4:0] i_modem_type_select,
   input  wire logic       i_main_carrier_valid,
   input  wire logic       i_back_carrier_valid,
   input  wire logic       i_main_demod_data,
   input  wire logic       i_back_demod_data,
   output logic            o_send_grant_n,
   output logic            o_back_send_grant_n,
   output logic            o_main_carrier_present_n,
   output logic            o_back_carrier_present_n,
   output logic            o_main_rx_serial,
   output logic            o_back_rx_serial,
   output logic            o_tx_tone_on,
   output logic [7:0]      o_tx_phase,
   output logic            o_tx_back_channel,
   output logic            o_rx_back_channel
);
   // -----------------------------------------
   // Mode decode
   // -----------------------------------------
   fsk_modem_pkg::mode_dec_t mdec;
   logic [3:0]               base;
   logic                     dtr_on;
   assign dtr_on = !i_terminal_ready_n;
   assign base   = i_modem_type_select[3:0];
   assign mdec.us300  = (base == `MODE_B103O) || (base == `MODE_B103A);
   assign mdec.v21    = (base == `MODE_V21O) || (base == `MODE_V21A);
   assign mdec.b202   = (base == `MODE_B202) || (base == `MODE_B202EQ);
   assign mdec.v23    = (base == `MODE_V23M2) || (base == `MODE_V23M2EQ)
                     || (base == `MODE_V23M1)
                     || (i_modem_type_select == `MODE_V23BKLB);
   // Half duplex covers the 1200/600 baud families
   assign mdec.half   = mdec.v23 || mdec.b202;
   assign mdec.answer = (base == `MODE_B103A) || (base == `MODE_V21A) || mdec.half;
   assign mdec.loop   = i_modem_type_select[4];
   assign mdec.valid  = mdec.us300 || mdec.v21 || mdec.half;

   // -----------------------------------------
   // Per-mode delays
   // -----------------------------------------
   logic [14:0] t_rcon;
   logic [14:0] t_sil;
   logic [14:0] t_at;
   logic [14:0] t_end;
   logic [14:0] t_on;
   logic [14:0] t_off;
   logic        rx_chan_reg;
   assign t_rcon = mdec.v21 ? `T_RCON_V21 : mdec.b202 ? `T_RCON_202 : `T_RCON_300;
   assign t_sil  = (mdec.us300 || mdec.b202) ? `T_SIL_US : `T_SIL_CCITT;
   assign t_at   = (mdec.us300 || mdec.b202) ? `T_AT_SHORT : `T_AT_LONG;
   assign t_end  = mdec.half ? `T_SQ : `T_RCOFF;
   assign t_on   = rx_chan_reg ? `T_BCDON : mdec.us300 ? `T_CDON_US300
                 : mdec.v21 ? `T_CDON_V21 : mdec.v23 ? `T_CDON_V23 : `T_CDON_202;
   assign t_off  = rx_chan_reg ? `T_BCDOFF : mdec.half
                 ? (mdec.v23 ? `T_CDOFF_V23 : `T_CDOFF_202) : `T_CDOFF_FULL;

   // -----------------------------------------
   // Transmit and answer machine
   // -----------------------------------------
   fsk_modem_pkg::tx_state_t tx_state_reg;
   fsk_modem_pkg::tx_state_t tx_state_next;
   logic [14:0]              tx_cnt_reg;
   logic [31:0]              tx_pre_reg;
   logic                     tx_tick;
   logic                     ans_flag_reg;
   logic                     main_act;
   logic                     answering;
   logic                     squelch;
   assign tx_tick   = (tx_pre_reg == 32'(TICK_CYCLES - 1));
   assign main_act  = (tx_state_reg == fsk_modem_pkg::TX_MAIN_WAIT)
                   || (tx_state_reg == fsk_modem_pkg::TX_MAIN_ON);
   assign answering = (tx_state_reg == fsk_modem_pkg::TX_SIL)
                   || (tx_state_reg == fsk_modem_pkg::TX_ANS);
   assign squelch   = (tx_state_reg == fsk_modem_pkg::TX_MAIN_OFF) && mdec.half;

   always_comb
   begin
      tx_state_next = tx_state_reg;
      if (!dtr_on || !mdec.valid)
         tx_state_next = fsk_modem_pkg::TX_INIT;
      else
         case (tx_state_reg)
            fsk_modem_pkg::TX_INIT: tx_state_next = fsk_modem_pkg::TX_IDLE;
            fsk_modem_pkg::TX_IDLE:
               if (!i_send_request_n)
                  tx_state_next = fsk_modem_pkg::TX_MAIN_WAIT;
               else if (mdec.half && !i_back_send_request_n)
                  tx_state_next = fsk_modem_pkg::TX_BACK_WAIT;
               else if (!i_ring_n && mdec.answer && !mdec.loop && !ans_flag_reg)
                  tx_state_next = fsk_modem_pkg::TX_SIL;
            fsk_modem_pkg::TX_SIL:
               if (tx_cnt_reg >= t_sil)
                  tx_state_next = fsk_modem_pkg::TX_ANS;
            fsk_modem_pkg::TX_ANS:
               if (tx_cnt_reg >= t_at)
                  tx_state_next = fsk_modem_pkg::TX_IDLE;
            fsk_modem_pkg::TX_MAIN_WAIT:
               if (i_send_request_n)
                  tx_state_next = fsk_modem_pkg::TX_MAIN_OFF;
               else if (tx_cnt_reg >= t_rcon)
                  tx_state_next = fsk_modem_pkg::TX_MAIN_ON;
            fsk_modem_pkg::TX_MAIN_ON:
               if (i_send_request_n)
                  tx_state_next = fsk_modem_pkg::TX_MAIN_OFF;
            fsk_modem_pkg::TX_MAIN_OFF:
               if (tx_cnt_reg >= t_end)
                  tx_state_next = fsk_modem_pkg::TX_IDLE;
            fsk_modem_pkg::TX_BACK_WAIT:
               if (i_back_send_request_n)
                  tx_state_next = fsk_modem_pkg::TX_BACK_OFF;
               else if (mdec.b202 || tx_cnt_reg >= `T_BRCON)
                  tx_state_next = fsk_modem_pkg::TX_BACK_ON;
            fsk_modem_pkg::TX_BACK_ON:
               if (i_back_send_request_n)
                  tx_state_next = fsk_modem_pkg::TX_BACK_OFF;
            fsk_modem_pkg::TX_BACK_OFF:
               if (tx_cnt_reg >= `T_RCOFF)
                  tx_state_next = fsk_modem_pkg::TX_IDLE;
            default: tx_state_next = fsk_modem_pkg::TX_INIT;
         endcase
   end

   // -----------------------------------------
   // Tone selection and synthesis
   // -----------------------------------------
   logic [11:0] hz_main;
   logic [11:0] hz_ans;
   logic [11:0] hz_back;
   logic [11:0] hz_sel;
   logic        tone_next;
   logic [28:0] ftw_prod;
   logic [31:0] acc_reg;
   // High on the data input is mark
   assign hz_main = (base == `MODE_B103O) ? (i_main_tx_serial ? `HZ_1270 : `HZ_1070)
                  : (base == `MODE_B103A) ? (i_main_tx_serial ? `HZ_2225 : `HZ_2025)
                  : (base == `MODE_V21O)  ? (i_main_tx_serial ? `HZ_980  : `HZ_1180)
                  : (base == `MODE_V21A)  ? (i_main_tx_serial ? `HZ_1650 : `HZ_1850)
                  : (base == `MODE_V23M1) ? (i_main_tx_serial ? `HZ_1300 : `HZ_1700)
                  : mdec.v23              ? (i_main_tx_serial ? `HZ_1300 : `HZ_2100)
                  : (i_main_tx_serial ? `HZ_1200 : `HZ_2200);
   assign hz_ans  = mdec.us300 ? `HZ_2225 : mdec.b202 ? `HZ_2025 : `HZ_2100;
   // US 1200 back channel is on/off keyed 387 Hz
   assign hz_back = mdec.b202 ? `HZ_387 : (i_back_tx_serial ? `HZ_390 : `HZ_450);
   assign hz_sel  = (tx_state_reg == fsk_modem_pkg::TX_ANS) ? hz_ans
                  : (tx_state_reg == fsk_modem_pkg::TX_MAIN_OFF) ? `HZ_1200
                  : ((tx_state_reg == fsk_modem_pkg::TX_BACK_WAIT)
                  || (tx_state_reg == fsk_modem_pkg::TX_BACK_ON)) ? hz_back : hz_main;
   // Soft turn-off tone in US 1200 modes
   assign tone_next = main_act || (tx_state_reg == fsk_modem_pkg::TX_ANS)
                   || (squelch && mdec.b202 && tx_cnt_reg < `T_STO)
                   || ((tx_state_reg == fsk_modem_pkg::TX_BACK_WAIT
                   || tx_state_reg == fsk_modem_pkg::TX_BACK_ON)
                   && (!mdec.b202 || i_back_tx_serial));
   // Fine tuning word keeps the error far under 0.4 Hz
   assign ftw_prod = 29'(hz_sel) * 29'(`FTW_MULT);

   // -----------------------------------------
   // Reception machine
   // -----------------------------------------
   fsk_modem_pkg::rx_state_t rx_state_reg;
   fsk_modem_pkg::rx_state_t rx_state_next;
   logic [14:0]              rx_cnt_reg;
   logic [31:0]              rx_pre_reg;
   logic                     rx_tick;
   logic                     rx_back;
   logic                     carrier;
   logic                     present;
   logic                     main_cd_on;
   logic                     back_cd_on;
   // In half duplex, receive filter on the back channel while main transmits or answers
   assign rx_back = mdec.half && (main_act || answering);
   assign carrier = rx_chan_reg ? i_back_carrier_valid : i_main_carrier_valid;
   assign rx_tick = (rx_pre_reg == 32'(TICK_CYCLES - 1));
   assign present = (rx_state_reg == fsk_modem_pkg::RX_PRES)
                 || (rx_state_reg == fsk_modem_pkg::RX_LOSS);
   // Clamp the carrier flags outside valid reception
   assign main_cd_on = present && !rx_chan_reg && !squelch && !answering;
   // Back flag only in half duplex
   assign back_cd_on = present && rx_chan_reg && mdec.half;

   always_comb
   begin
      rx_state_next = rx_state_reg;
      // Held in initial conditions until terminal ready
      if (!dtr_on || !mdec.valid)
         rx_state_next = fsk_modem_pkg::RX_INIT;
      else if (rx_back != rx_chan_reg)
         rx_state_next = fsk_modem_pkg::RX_NONE;
      else
         case (rx_state_reg)
            fsk_modem_pkg::RX_INIT: rx_state_next = fsk_modem_pkg::RX_NONE;
            fsk_modem_pkg::RX_NONE:
               if (carrier)
                  rx_state_next = fsk_modem_pkg::RX_QUAL;
            // Back and main qualification share this path
            fsk_modem_pkg::RX_QUAL:
               if (!carrier)
                  rx_state_next = fsk_modem_pkg::RX_NONE;
               else if (rx_cnt_reg >= t_on)
                  rx_state_next = fsk_modem_pkg::RX_PRES;
            fsk_modem_pkg::RX_PRES:
               if (!carrier)
                  rx_state_next = fsk_modem_pkg::RX_LOSS;
            fsk_modem_pkg::RX_LOSS:
               if (carrier)
                  rx_state_next = fsk_modem_pkg::RX_PRES;
               else if (rx_cnt_reg >= t_off)
                  rx_state_next = fsk_modem_pkg::RX_NONE;
            default: rx_state_next = fsk_modem_pkg::RX_INIT;
         endcase
   end

   // -----------------------------------------
   // Registers
   // -----------------------------------------
   logic grant_next;
   logic bgrant_next;
   // Grant holds through the off delay
   assign grant_next  = (tx_state_reg == fsk_modem_pkg::TX_MAIN_ON) ? 1'b0
                      : (tx_state_reg == fsk_modem_pkg::TX_MAIN_OFF && tx_cnt_reg < `T_RCOFF)
                      ? o_send_grant_n : 1'b1;
   assign bgrant_next = (tx_state_reg == fsk_modem_pkg::TX_BACK_ON && mdec.v23) ? 1'b0
                      : (tx_state_reg == fsk_modem_pkg::TX_BACK_OFF && tx_cnt_reg < `T_RCOFF)
                      ? o_back_send_grant_n : 1'b1;

   // Counters restart on every state change so delays start exact
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         tx_state_reg <= fsk_modem_pkg::TX_INIT;
         tx_cnt_reg   <= 15'h0000;
         tx_pre_reg   <= 32'h0000_0000;
      end
      else
      begin
         tx_state_reg <= tx_state_next;
         tx_pre_reg   <= (tx_state_next != tx_state_reg || tx_tick) ? 32'h0000_0000
                                                                     : tx_pre_reg + 32'h1;
         tx_cnt_reg   <= (tx_state_next != tx_state_reg) ? 15'h0000
                       : tx_cnt_reg + {14'h0000, tx_tick};
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         rx_state_reg <= fsk_modem_pkg::RX_INIT;
         rx_chan_reg  <= 1'b0;
         rx_cnt_reg   <= 15'h0000;
         rx_pre_reg   <= 32'h0000_0000;
      end
      else
      begin
         rx_state_reg <= rx_state_next;
         rx_chan_reg  <= rx_back;
         rx_pre_reg   <= (rx_state_next != rx_state_reg || rx_tick) ? 32'h0000_0000
                                                                     : rx_pre_reg + 32'h1;
         rx_cnt_reg   <= (rx_state_next != rx_state_reg) ? 15'h0000
                       : rx_cnt_reg + {14'h0000, rx_tick};
      end
   end

   // Answer flag blocks a second auto-answer until terminal ready cycles
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         ans_flag_reg <= 1'b0;
      else if (tx_state_reg == fsk_modem_pkg::TX_SIL)
         ans_flag_reg <= 1'b1;
      else if (!dtr_on)
         ans_flag_reg <= 1'b0;
   end

   // Accumulator never reloads, so tone switches keep phase
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         acc_reg <= 32'h0000_0000;
      else
         acc_reg <= acc_reg + {15'h0000, ftw_prod[28:`FTW_SHIFT]};
   end

   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_send_grant_n           <= 1'b1;
         o_back_send_grant_n      <= 1'b1;
         o_main_carrier_present_n <= 1'b1;
         o_back_carrier_present_n <= 1'b1;
         o_main_rx_serial         <= 1'b1;
         o_back_rx_serial         <= 1'b1;
         o_tx_tone_on             <= 1'b0;
         o_tx_phase               <= 8'h00;
         o_tx_back_channel        <= 1'b0;
         o_rx_back_channel        <= 1'b0;
      end
      else
      begin
         o_send_grant_n           <= grant_next;
         o_back_send_grant_n      <= bgrant_next;
         o_main_carrier_present_n <= !main_cd_on;
         // Low while the back tone is qualified
         o_back_carrier_present_n <= !back_cd_on;
         // Mark whenever data may be invalid
         o_main_rx_serial         <= main_cd_on ? i_main_demod_data : 1'b1;
         o_back_rx_serial         <= (back_cd_on && mdec.v23) ? i_back_demod_data : 1'b1;
         o_tx_tone_on             <= tone_next;
         o_tx_phase               <= acc_reg[ACC_W-1 -: 8];
         o_tx_back_channel        <= mdec.half && !main_act && !answering;
         o_rx_back_channel        <= rx_back;
      end
   end

   // -----------------------------------------
   // Assertions
   // -----------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   sequence s_dtr_drop;
      $fell(dtr_on);
   endsequence
   sequence s_init_out;
      o_send_grant_n && o_main_carrier_present_n && o_main_rx_serial;
   endsequence
   a_dtr_drop_init: assert property (s_dtr_drop |=> tx_state_reg == fsk_modem_pkg::TX_INIT
      && rx_state_reg == fsk_modem_pkg::RX_INIT) else $error("No init after drop");
   a_init_outputs: assert property (s_dtr_drop ##2 1'b1 |-> s_init_out)
      else $error("Outputs not idle");
   a_grant_path: assert property ($fell(o_send_grant_n)
      |-> $past(tx_state_reg, 2) == fsk_modem_pkg::TX_MAIN_WAIT) else $error("Early grant");
   a_grant_hold: assert property (tx_state_reg == fsk_modem_pkg::TX_MAIN_ON
      ##1 tx_state_reg == fsk_modem_pkg::TX_MAIN_OFF |=> !o_send_grant_n)
      else $error("Grant dropped early");
   a_rd_clamp: assert property (!main_cd_on |=> o_main_rx_serial)
      else $error("Data not mark");
   a_back_full: assert property (!mdec.half [*2] |-> o_back_send_grant_n
      && o_back_carrier_present_n) else $error("Back live in full duplex");
   a_silence_quiet: assert property (tx_state_reg == fsk_modem_pkg::TX_SIL |=> !o_tx_tone_on)
      else $error("Tone in silence");
   a_back_keying: assert property (tx_state_reg == fsk_modem_pkg::TX_BACK_ON && mdec.b202
      && !i_back_tx_serial |=> !o_tx_tone_on) else $error("Back tone with data low");
   a_qual_abort: assert property (rx_state_reg == fsk_modem_pkg::RX_QUAL && !carrier
      && rx_back == rx_chan_reg && dtr_on && mdec.valid
      |=> rx_state_reg == fsk_modem_pkg::RX_NONE) else $error("Qualify kept");
endmodule : fsk_modem_interface_control

// File: testbench/fsk_term_model.sv
// Terminal-side model: ready, send request, transmit data and ring
module fsk_term_model
(
   input  wire logic i_clock,
   input  wire logic i_enable,
   input  wire logic i_go,
   input  wire logic i_grant_n,
   output logic      o_terminal_ready_n,
   output logic      o_send_request_n,
   output logic      o_main_tx_serial,
   output logic      o_ring_n
);
   timeunit 1ns;
   timeprecision 1ps;
   int seed = 18;
   assign o_terminal_ready_n = ~i_enable;
   assign o_send_request_n   = ~i_go;
   // Ring held off, no short pulse
   assign o_ring_n = 1'b1;
   always @(negedge i_clock)
      o_main_tx_serial <= i_grant_n ? 1'b1 : 1'($random(seed) & 1);
endmodule : fsk_term_model

// File: testbench/fsk_modem_interface_control_tb_top.sv
// Self-checking bench of the FSK modem interface control
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module fsk_modem_interface_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // -----------------------------------------
   // Setup
   // -----------------------------------------
   localparam int T = 4;
   logic       i_clock, i_sys_rst, enable, go, carrier, demod, back_req_n;
   logic [4:0] mode;
   logic       rdy_n, req_n, txd, ring_n, grant_n, bgrant_n, cd_n, bcd_n, rxd, brxd;
   logic       tone, txb, rxb;
   logic [7:0] phase;
   int         err_count, checks, cycles, seed;
   fsk_modem_interface_control #(.TICK_CYCLES(T)) u_dut (.i_clock(i_clock),
      .i_sys_rst(i_sys_rst), .i_terminal_ready_n(rdy_n), .i_send_request_n(req_n),
      .i_back_send_request_n(back_req_n), .i_main_tx_serial(txd), .i_back_tx_serial(1'b1),
      .i_ring_n(ring_n), .i_modem_type_select(mode), .i_main_carrier_valid(carrier),
      .i_back_carrier_valid(1'b0), .i_main_demod_data(demod), .i_back_demod_data(demod),
      .o_send_grant_n(grant_n), .o_back_send_grant_n(bgrant_n),
      .o_main_carrier_present_n(cd_n), .o_back_carrier_present_n(bcd_n),
      .o_main_rx_serial(rxd), .o_back_rx_serial(brxd), .o_tx_tone_on(tone),
      .o_tx_phase(phase), .o_tx_back_channel(txb), .o_rx_back_channel(rxb));
   fsk_term_model u_term (.i_clock(i_clock), .i_enable(enable), .i_go(go),
      .i_grant_n(grant_n), .o_terminal_ready_n(rdy_n), .o_send_request_n(req_n),
      .o_main_tx_serial(txd), .o_ring_n(ring_n));
   initial
   begin
      i_clock = 1'b0;
      forever #2.5 i_clock = ~i_clock;
   end
   task automatic summarize();
      $display("comparisons=%0d mismatches=%0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : summarize
   // Long delays make a hang costly, so cut it at a fixed ceiling
   always @(posedge i_clock)
   begin
      cycles++;
      if (cycles == 80000)
      begin
         err_count++;
         summarize();
      end
   end
   task automatic cyc(int n);
      repeat (n) @(negedge i_clock);
   endtask : cyc
   // -----------------------------------------
   // Main send sequence per mode
   // -----------------------------------------
   task automatic main_req(logic [4:0] m, int rcon, logic half);
      mode = m;
      go   = 1'b1;
      cyc(rcon * T - 2);
      `CHK(grant_n, 1'b1)
      cyc(10);
      `CHK(grant_n, 1'b0)
      `CHK(tone, 1'b1)
      `CHK(rxb, half)
      `CHK(bgrant_n, 1'b1)
      go = 1'b0;
      cyc(5 * T - 2);
      `CHK(grant_n, 1'b0)
      cyc(10);
      `CHK(grant_n, 1'b1)
      cyc(half ? 1600 * T : 10);
   endtask : main_req
   initial
   begin
      seed = 18; i_sys_rst = 1'b1; enable = 1'b0; go = 1'b0; carrier = 1'b0;
      demod = 1'b1; back_req_n = 1'b1; mode = 5'h00;
      cyc(8);
      i_sys_rst = 1'b0;
      `CHK({grant_n, bgrant_n, cd_n, bcd_n, rxd, brxd, tone}, 7'h7E)
      go = 1'b1;
      cyc(200);
      `CHK(grant_n, 1'b1)
      go = 1'b0; enable = 1'b1;
      cyc(4);
      main_req(5'h00, 2083, 1'b0);
      main_req(5'h04, 4000, 1'b0);
      main_req(5'h02, 1833, 1'b1);
      // Carrier qualify, data follow, loss
      mode = 5'h00; carrier = 1'b1;
      cyc(1000 * T - 3);
      `CHK(cd_n, 1'b1)
      cyc(10);
      `CHK(cd_n, 1'b0)
      repeat (20)
      begin
         demod = 1'($random(seed) & 1);
         cyc(3);
         `CHK(rxd, demod)
      end
      carrier = 1'b0; demod = 1'b0;
      cyc(300 * T - 3);
      `CHK(cd_n, 1'b0)
      cyc(10);
      `CHK({cd_n, rxd}, 2'h3)
      // Back channel ignored full duplex, granted in V.23
      back_req_n = 1'b0;
      cyc(823 * T + 10);
      `CHK(bgrant_n, 1'b1)
      back_req_n = 1'b1; mode = 5'h06;
      cyc(4);
      back_req_n = 1'b0;
      cyc(823 * T - 3);
      `CHK(bgrant_n, 1'b1)
      cyc(10);
      `CHK({bgrant_n, txb}, 2'h1)
      back_req_n = 1'b1;
      cyc(1600 * T);
      // Terminal ready off mid-transfer
      mode = 5'h00; carrier = 1'b1; go = 1'b1;
      cyc(2100 * T);
      enable = 1'b0;
      cyc(5000);
      `CHK({grant_n, cd_n, rxd, tone}, 4'hE)
      summarize();
   end
endmodule : fsk_modem_interface_control_tb_top
